/* sbdp_agent.sv */
// Far-side bus agent model: drives data bursts, in-use and indication_a
`timescale 1ns/1ps
module sbdp_agent
	import sbdp_pkg::*;
(
	// Clock
	input wire logic clk,
	// Bus drive
	output logic oe,
	output logic [SBDP_DATA_W-1:0] data_n,
	output logic [SBDP_CHECK_W-1:0] check_n,
	output logic strobe_n,
	output logic inuse_n,
	output logic indication_a_n
);
	initial
	begin
		oe = 1'b0;
		data_n = '1;
		check_n = '1;
		strobe_n = 1'b1;
		inuse_n = 1'b1;
		indication_a_n = 1'b1;
	end
	// One idle clock after each word; data inverts so stale values never look valid
	task automatic burst(input sbdp_word_t w[$], input bit hold);
		@(posedge clk);
		oe <= 1'b1;
		inuse_n <= 1'b0;
		foreach (w[i])
		begin
			@(posedge clk);
			data_n <= ~w[i].data;
			check_n <= ~w[i].check;
			strobe_n <= 1'b0;
			@(posedge clk);
			strobe_n <= 1'b1;
			data_n <= w[i].data;
		end
		if (!hold)
			release_bus();
	endtask : burst
	task automatic release_bus();
		@(posedge clk);
		oe <= 1'b0;
		inuse_n <= 1'b1;
	endtask : release_bus
	task automatic indication_a(input bit on);
		@(posedge clk);
		indication_a_n <= !on;
	endtask : indication_a
endmodule : sbdp_agent

/* sbdp_data_phase.sv */
// Data phase of the shared system bus as seen inside the processor
// Notes on behaviour
// - Differential mode: reference pin is complement clock
// - 64-bit shared bidirectional data path
// - Driver asserts valid strobe on valid words
// - Strobe may drop for idle clocks
// - Owner holds in-use while occupying bus
// - Check lines driven by data driver
// - Check enable fixed at power-on configuration
`timescale 1ns/1ps
module sbdp_data_phase
	import sbdp_pkg::*;
#(
	parameter int DEPTH = SBDP_FIFO_DEPTH
)(
	// Clock and reset
	input wire logic CLK,
	input wire logic NRST,
	// Configuration straps
	input wire logic CHECK_STRAP,
	input wire logic DIFF_CLOCK_MODE,
	input wire logic PLL_REFERENCE_INPUT,
	input wire logic TERMINATION_POWER_GOOD,
	input wire logic [1:0] SPEED_STRAP,
	output logic [1:0] BUS_SPEED_SELECT,
	output logic BUS_SPEED_SELECT_OE,
	output logic COMPLEMENT_CLOCK,
	output logic PLL_REFERENCE_SEL,
	// Core write side
	input wire logic TX_VALID,
	output logic TX_READY,
	input wire logic [SBDP_DATA_W-1:0] TX_DATA,
	input wire logic [7:0] TX_BEATS,
	input wire logic TX_START,
	output logic TX_BUSY,
	// Core read side
	output logic RX_VALID,
	output logic [SBDP_DATA_W-1:0] RX_DATA,
	output logic RX_CHECK_ERR,
	output logic INDICATION_A_SEEN,
	// Bus pins, active low on the wire
	input wire logic [SBDP_DATA_W-1:0] DATA_N_I,
	output logic [SBDP_DATA_W-1:0] DATA_N_O,
	output logic DATA_OE,
	input wire logic [SBDP_CHECK_W-1:0] DATA_CHECK_LINES_N_I,
	output logic [SBDP_CHECK_W-1:0] DATA_CHECK_LINES_N_O,
	output logic DATA_CHECK_LINES_OE,
	input wire logic DATA_VALID_STROBE_N_I,
	output logic DATA_VALID_STROBE_N_O,
	output logic DATA_VALID_STROBE_OE,
	input wire logic DATA_BUS_IN_USE_N_I,
	output logic DATA_BUS_IN_USE_N_O,
	output logic DATA_BUS_IN_USE_OE,
	input wire logic INDICATION_A_N_I
);
	// Pin synchronisers: first stage read only by second
	logic [SBDP_DATA_W-1:0] d_s1, d_s2;
	logic [SBDP_CHECK_W-1:0] c_s1, c_s2;
	logic [4:0] m_s1, m_s2;
	always_ff @(posedge CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			d_s1 <= '0;
			d_s2 <= '0;
			c_s1 <= '0;
			c_s2 <= '0;
			m_s1 <= '0;
			m_s2 <= '0;
		end
		else
		begin
			d_s1 <= ~DATA_N_I;
			d_s2 <= d_s1;
			c_s1 <= ~DATA_CHECK_LINES_N_I;
			c_s2 <= c_s1;
			m_s1 <= {~DATA_VALID_STROBE_N_I, ~DATA_BUS_IN_USE_N_I, ~INDICATION_A_N_I,
				TERMINATION_POWER_GOOD, DIFF_CLOCK_MODE};
			m_s2 <= m_s1;
		end
	end
	wire rx_strobe = m_s2[4];
	wire bus_busy_other = m_s2[3];
	wire indication_a_in = m_s2[2];
	wire pwr_good = m_s2[1];
	wire diff_mode = m_s2[0];

	// Differential mode turns the reference pin into the complementary clock
	assign PLL_REFERENCE_SEL = !diff_mode;
	assign COMPLEMENT_CLOCK = diff_mode && PLL_REFERENCE_INPUT;

	// Check and speed straps are caught once, on the first clock after reset release
	logic cfg_done_reg, check_en_reg;
	logic [1:0] speed_reg;
	always_ff @(posedge CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			cfg_done_reg <= 1'b0;
			check_en_reg <= 1'b0;
			speed_reg <= 2'b00;
		end
		else if (!cfg_done_reg)
		begin
			cfg_done_reg <= 1'b1;
			check_en_reg <= CHECK_STRAP;
			speed_reg <= SPEED_STRAP;
		end
	end
	// Select lines only driven once termination power is good
	assign BUS_SPEED_SELECT = speed_reg;
	assign BUS_SPEED_SELECT_OE = cfg_done_reg && pwr_good;

	// Outgoing words queue in the FIFO; TX_READY stalls the core when full
	sbdp_word_t fifo_in, fifo_out;
	logic fifo_out_valid, fifo_pop;
	assign fifo_in = {TX_DATA, sbdp_check(TX_DATA)};
	sbdp_fifo #(.WIDTH($bits(sbdp_word_t)), .DEPTH(DEPTH)) u_fifo (
		.clk(CLK),
		.nrst(NRST),
		.in_valid(TX_VALID),
		.in_ready(TX_READY),
		.in_data(fifo_in),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_out)
	);

	// Driver state machine
	sbdp_state_t state_reg, state_next;
	logic [7:0] beats_reg, beats_next;
	logic strobe_reg, own_reg;
	// Our own drive comes back through the pin synchronisers two clocks late
	logic own_d1_reg, own_d2_reg;
	sbdp_word_t word_reg;
	wire can_start = TX_START && !(bus_busy_other && !own_d2_reg) && cfg_done_reg;
	wire last_beat = (beats_reg == 8'h01);
	wire in_drive = (state_reg == SBDP_DRIVE);
	// Empty FIFO mid-transfer inserts an idle clock rather than stalling bus
	assign fifo_pop = in_drive && fifo_out_valid && (beats_reg != '0);

	always_comb
	begin
		state_next = state_reg;
		beats_next = beats_reg;
		unique case (state_reg)
			SBDP_IDLE:
				if (can_start && TX_BEATS != '0)
				begin
					state_next = SBDP_DRIVE;
					beats_next = (TX_BEATS > SBDP_BEAT_MAX) ? SBDP_BEAT_MAX : TX_BEATS;
				end
			SBDP_DRIVE:
				if (fifo_pop)
				begin
					beats_next = beats_reg - 8'h01;
					if (last_beat)
						state_next = SBDP_RELEASE;
				end
			SBDP_RELEASE:
				state_next = SBDP_IDLE;
			default:
				state_next = SBDP_IDLE;
		endcase
	end

	always_ff @(posedge CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			state_reg <= SBDP_IDLE;
			beats_reg <= SBDP_WORDS_RESET;
			strobe_reg <= 1'b0;
			own_reg <= 1'b0;
			own_d1_reg <= 1'b0;
			own_d2_reg <= 1'b0;
			word_reg <= '0;
		end
		else
		begin
			state_reg <= state_next;
			beats_reg <= beats_next;
			strobe_reg <= fifo_pop;
			// Held through RELEASE so the last word's strobe is still ours
			own_reg <= (state_next != SBDP_IDLE);
			own_d1_reg <= own_reg;
			own_d2_reg <= own_d1_reg;
			if (fifo_pop)
				word_reg <= fifo_out;
		end
	end

	// Data, check and strobe all come from the same clock's registers
	assign DATA_OE = own_reg;
	assign DATA_N_O = ~word_reg.data;
	assign DATA_CHECK_LINES_OE = own_reg && check_en_reg;
	assign DATA_CHECK_LINES_N_O = ~word_reg.check;
	assign DATA_VALID_STROBE_OE = own_reg;
	assign DATA_VALID_STROBE_N_O = ~strobe_reg;
	assign DATA_BUS_IN_USE_OE = own_reg;
	assign DATA_BUS_IN_USE_N_O = ~own_reg;
	assign TX_BUSY = own_reg;

	// Receive: data counts only in clocks the other driver strobes
	wire rx_take = rx_strobe && !own_d2_reg;
	logic rx_valid_reg, rx_err_reg, indication_a_reg;
	logic [SBDP_DATA_W-1:0] rx_data_reg;
	always_ff @(posedge CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			rx_valid_reg <= 1'b0;
			rx_err_reg <= 1'b0;
			indication_a_reg <= 1'b0;
			rx_data_reg <= '0;
		end
		else
		begin
			rx_valid_reg <= rx_take;
			rx_err_reg <= rx_take && check_en_reg && (sbdp_check(d_s2) != c_s2);
			indication_a_reg <= indication_a_in;
			if (rx_take)
				rx_data_reg <= d_s2;
		end
	end
	assign RX_VALID = rx_valid_reg;
	assign RX_DATA = rx_data_reg;
	assign RX_CHECK_ERR = rx_err_reg;
	assign INDICATION_A_SEEN = indication_a_reg;

	a_strobe_needs_owner: assert property (@(posedge CLK) disable iff (!NRST)
		!DATA_VALID_STROBE_N_O |-> DATA_BUS_IN_USE_OE)
		else $error("strobe driven without bus ownership");
	a_inuse_follows_owner: assert property (@(posedge CLK) disable iff (!NRST)
		(!DATA_BUS_IN_USE_N_O) == (state_reg != SBDP_IDLE))
		else $error("in-use pin out of step with ownership");
	a_release_drops_use: assert property (@(posedge CLK) disable iff (!NRST)
		(state_reg == SBDP_RELEASE) |=> (!own_reg && state_reg == SBDP_IDLE))
		else $error("bus held past release");
	a_check_fixed_cfg: assert property (@(posedge CLK) disable iff (!NRST)
		cfg_done_reg |=> $stable(check_en_reg))
		else $error("check enable changed after configuration");
	a_check_gated_en: assert property (@(posedge CLK) disable iff (!NRST)
		DATA_CHECK_LINES_OE |-> (check_en_reg && DATA_OE))
		else $error("check lines driven without data");
	a_check_same_word: assert property (@(posedge CLK) disable iff (!NRST)
		!DATA_VALID_STROBE_N_O |-> (~DATA_CHECK_LINES_N_O == sbdp_check(~DATA_N_O)))
		else $error("check byte does not match strobed word");
	a_speed_after_good: assert property (@(posedge CLK) disable iff (!NRST)
		BUS_SPEED_SELECT_OE |-> pwr_good)
		else $error("speed select driven before power good");
	a_pop_loads_word: assert property (@(posedge CLK) disable iff (!NRST)
		fifo_pop |=> (!DATA_VALID_STROBE_N_O && word_reg == $past(fifo_out)))
		else $error("popped word not presented next clock");
	a_ref_pin_mode: assert property (@(posedge CLK) disable iff (!NRST)
		diff_mode |-> !PLL_REFERENCE_SEL)
		else $error("reference pin not released in differential mode");
endmodule : sbdp_data_phase

/* sbdp_data_phase_tb_top.sv */
// Testbench for the system bus data phase block
`timescale 1ns/1ps
module sbdp_data_phase_tb_top
	import sbdp_pkg::*;
;
	logic clk, nrst, strap, dcm, pin, pg, tx_valid, tx_start;
	logic [1:0] spd, sstrap;
	logic spd_oe, cclk, psel, tx_ready, tx_busy, rx_valid, rx_err, dfs;
	logic [63:0] tx_data, rx_data, d_o, a_d, d_w;
	logic [7:0] beats, c_o, a_c, c_w;
	logic d_oe, c_oe, s_o, s_oe, u_o, u_oe, a_oe, a_s, a_u, a_f, s_w, u_w;
	int err_count = 0, num_checks = 0, nooe = 0, rxerr = 0;
	sbdp_word_t txq[$], rxq[$];
	// Released lines float to their pull-up
	assign d_w = d_oe ? d_o : a_oe ? a_d : '1;
	assign c_w = c_oe ? c_o : a_oe ? a_c : '1;
	assign s_w = s_oe ? s_o : a_oe ? a_s : 1'b1;
	assign u_w = u_oe ? u_o : a_oe ? a_u : 1'b1;
	sbdp_data_phase i_dut (.CLK(clk), .NRST(nrst), .CHECK_STRAP(strap), .DIFF_CLOCK_MODE(dcm),
		.PLL_REFERENCE_INPUT(pin), .TERMINATION_POWER_GOOD(pg), .SPEED_STRAP(sstrap),
		.BUS_SPEED_SELECT(spd), .BUS_SPEED_SELECT_OE(spd_oe), .COMPLEMENT_CLOCK(cclk),
		.PLL_REFERENCE_SEL(psel), .TX_VALID(tx_valid), .TX_READY(tx_ready), .TX_DATA(tx_data),
		.TX_BEATS(beats), .TX_START(tx_start), .TX_BUSY(tx_busy), .RX_VALID(rx_valid),
		.RX_DATA(rx_data), .RX_CHECK_ERR(rx_err), .INDICATION_A_SEEN(dfs), .DATA_N_I(d_w),
		.DATA_N_O(d_o), .DATA_OE(d_oe), .DATA_CHECK_LINES_N_I(c_w),
		.DATA_CHECK_LINES_N_O(c_o), .DATA_CHECK_LINES_OE(c_oe), .DATA_VALID_STROBE_N_I(s_w),
		.DATA_VALID_STROBE_N_O(s_o), .DATA_VALID_STROBE_OE(s_oe), .DATA_BUS_IN_USE_N_I(u_w),
		.DATA_BUS_IN_USE_N_O(u_o), .DATA_BUS_IN_USE_OE(u_oe), .INDICATION_A_N_I(a_f));
	sbdp_agent i_agent (.clk(clk), .oe(a_oe), .data_n(a_d), .check_n(a_c), .strobe_n(a_s),
		.inuse_n(a_u), .indication_a_n(a_f));
	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	always @(posedge clk)
	begin
		if (s_oe && !s_o)
			txq.push_back({~d_o, ~c_o});
		if (!s_o && !(s_oe && c_oe && u_oe && !u_o))
			nooe++;
		if (rx_valid)
			rxq.push_back({rx_data, 8'h00});
		if (rx_err)
			rxerr++;
	end
	function automatic logic [7:0] par(input logic [63:0] d);
		logic [7:0] c;
		for (int i = 0; i < 8; i++)
			c[i] = ^d[i*8 +: 8];
		return c;
	endfunction : par
	function automatic logic [63:0] wd(input int i);
		return 64'h0123456789abcdef * (i + 1);
	endfunction : wd
	task automatic chk(input logic [71:0] seen, input logic [71:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic t_cfg();
		chk(spd, 2'b11);
		chk(spd_oe, 1'b1);
		dcm <= 1'b1;
		pin <= 1'b1;
		repeat (5) @(posedge clk);
		chk({cclk, psel}, 2'b10);
	endtask : t_cfg
	task automatic t_fill_tx();
		int n;
		n = 0;
		tx_valid <= 1'b1;
		tx_data <= wd(0);
		for (int k = 0; k < 40 && n < 32; k++)
		begin
			@(posedge clk);
			if (tx_ready)
				n++;
			tx_data <= wd(n);
		end
		tx_valid <= 1'b0;
		@(posedge clk);
		chk(tx_ready, 1'b0);
		chk(n, 32);
		strap <= 1'b0;
		for (int t = 0; t < 8; t++)
		begin
			beats <= (t == 7) ? 8'hff : 8'h04;
			tx_start <= 1'b1;
			for (int k = 0; k < 10 && !tx_busy; k++)
				@(posedge clk);
			tx_start <= 1'b0;
			for (int k = 0; k < 50 && tx_busy; k++)
				@(posedge clk);
			repeat (3) @(posedge clk);
		end
		chk(txq.size(), 32);
		foreach (txq[i])
			chk(txq[i], {wd(i), par(wd(i))});
		chk(nooe, 0);
	endtask : t_fill_tx
	task automatic t_rx();
		sbdp_word_t w[$];
		for (int i = 0; i < 3; i++)
			w.push_back({wd(i + 40), par(wd(i + 40))});
		w.push_back({wd(50), ~par(wd(50))});
		i_agent.burst(w, 0);
		repeat (10) @(posedge clk);
		chk(rxq.size(), 4);
		foreach (rxq[i])
			chk(rxq[i], {w[i].data, 8'h00});
		chk(rxerr, 1);
	endtask : t_rx
	task automatic t_refuse();
		sbdp_word_t w[$];
		int busy;
		busy = 0;
		i_agent.burst(w, 1);
		repeat (4) @(posedge clk);
		tx_start <= 1'b1;
		beats <= 8'h01;
		repeat (8)
		begin
			@(posedge clk);
			busy += tx_busy;
		end
		tx_start <= 1'b0;
		i_agent.release_bus();
		chk(busy, 0);
	endtask : t_refuse
	task automatic t_indication_a();
		i_agent.indication_a(1);
		repeat (5) @(posedge clk);
		chk(dfs, 1'b1);
		i_agent.indication_a(0);
		repeat (5) @(posedge clk);
		chk(dfs, 1'b0);
	endtask : t_indication_a
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : tally_and_finish
	initial
	begin
		nrst = 1'b0;
		strap = 1'b1;
		dcm = 1'b0;
		pin = 1'b0;
		pg = 1'b1;
		sstrap = 2'b11;
		tx_valid = 1'b0;
		tx_start = 1'b0;
		tx_data = '0;
		beats = 8'h04;
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		repeat (4) @(posedge clk);
		t_cfg();
		t_fill_tx();
		t_rx();
		t_refuse();
		t_indication_a();
		tally_and_finish();
	end
	initial
	begin
		repeat (5000) @(posedge clk);
		err_count++;
		tally_and_finish();
	end
endmodule : sbdp_data_phase_tb_top

/* sbdp_fifo.sv */
// Word FIFO between the core side and the bus data driver
`timescale 1ns/1ps
module sbdp_fifo
	import sbdp_pkg::*;
#(
	parameter int WIDTH = 72,
	parameter int DEPTH = 32
)(
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_reg;
	logic [AW-1:0] rd_reg;
	logic [AW:0] count_reg;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;

	assign in_ready = (count_reg != (AW+1)'(DEPTH));
	assign out_valid = (count_reg != '0);
	assign out_data = mem[rd_reg];

	always_ff @(posedge clk)
	begin
		if (push)
			mem[wr_reg] <= in_data;
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			wr_reg <= '0;
			rd_reg <= '0;
			count_reg <= '0;
		end
		else
		begin
			if (push)
				wr_reg <= (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
			if (pop)
				rd_reg <= (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
			count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	a_fifo_no_overflow: assert property (@(posedge clk) disable iff (!nrst)
		(count_reg == (AW+1)'(DEPTH)) |-> !push)
		else $error("fifo written while full");
	a_fifo_count_step: assert property (@(posedge clk) disable iff (!nrst)
		(push && !pop) |=> (count_reg == $past(count_reg) + 1'b1))
		else $error("fifo count did not step on push");
endmodule : sbdp_fifo

/* sbdp_pkg.sv */
// Package for the system bus data phase block: widths, codes and carriers
package sbdp_pkg;
	localparam int SBDP_DATA_W = 64;
	localparam int SBDP_CHECK_W = 8;
	localparam int SBDP_FIFO_DEPTH = 32;
	localparam logic [7:0] SBDP_WORDS_RESET = 8'h00;
	localparam logic [7:0] SBDP_BEAT_MAX = 8'h04;

	typedef struct packed {
		logic [SBDP_DATA_W-1:0] data;
		logic [SBDP_CHECK_W-1:0] check;
	} sbdp_word_t;

	typedef enum logic [1:0] {
		SBDP_IDLE = 2'b00,
		SBDP_DRIVE = 2'b01,
		SBDP_RELEASE = 2'b10
	} sbdp_state_t;

	// Check byte: parity of each data byte, one bit per byte
	function automatic logic [SBDP_CHECK_W-1:0] sbdp_check(input logic [SBDP_DATA_W-1:0] d);
		logic [SBDP_CHECK_W-1:0] c;
		c = '0;
		for (int i = 0; i < SBDP_CHECK_W; i++)
			c[i] = ^d[i*8 +: 8];
		return c;
	endfunction : sbdp_check
endpackage : sbdp_pkg
